// >>> include/bbc_pkg.sv
// shared constants for the regulator configuration register bank
package bbc_pkg;
  // clock and ramp timing
  localparam int CLK_PERIOD_NS = 40; // system clock period
  localparam int RAMP_STEP_NS = 50000; // one ramp step every 50 us
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // output level field
  localparam int LEVEL_W = 6; // width of the output level code
  localparam logic [5:0] LEVEL_MAX = 6'h3C; // codes at or above select top level
  // serial port
  localparam logic [6:0] DEV_ADDR = 7'h28; // seven-bit bus address
  localparam logic [3:0] BYTE_BITS = 4'h8; // bits per byte
  // register offsets
  localparam logic [7:0] REG_CHIP = 8'h00;
  localparam logic [7:0] REG_CFG_A = 8'h01;
  localparam logic [7:0] REG_LEVEL = 8'h02;
  localparam logic [7:0] REG_PEAK = 8'h03;
  localparam logic [7:0] REG_CFG_B = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_EVENTS = 8'h06;
  localparam logic [7:0] REG_SUPPRESS = 8'h07;
  localparam logic [7:0] REG_GUARD = 8'h50;
  localparam logic [7:0] REG_PASSWORD = 8'h51;
  // field positions in config a
  localparam int A_ON = 7;
  localparam int A_RAMP = 6;
  localparam int A_QUICK = 5;
  localparam int A_ZC_OFF = 4;
  localparam int A_SLOW = 3;
  localparam int A_TOPO = 2;
  localparam int A_ACTIVE = 1;
  localparam int A_PASSIVE = 0;
  // field positions in config b
  localparam int B_GATE = 7;
  localparam int B_BYPASS = 6;
  localparam int B_SUPPLY = 5;
  localparam int B_INTEG = 2;
  localparam int B_ADAPT = 1;
  localparam int B_HALVE = 0;
  // masks for write behaviour
  localparam logic [7:0] A_LATCH_MASK = 8'h14; // bits held while enabled
  localparam logic [7:0] B_LATCH_MASK = 8'h05; // bits held while enabled
  localparam logic [7:0] B_WRITE_MASK = 8'hE7; // implemented bits of config b
  // password codes
  localparam logic [7:0] LOCK_CODE = 8'hAA;
  localparam logic [7:0] UNLOCK_CODE = 8'h55;
  // reset values
  localparam logic [7:0] RST_CFG_A = 8'h13;
  localparam logic [7:0] RST_LEVEL = 8'hCE;
  localparam logic [7:0] RST_PEAK = 8'h84;
  localparam logic [7:0] RST_CFG_B = 8'h01;
  localparam logic [1:0] RST_SUPPRESS = 2'h3;
  localparam logic RST_GUARD = 1'b1;
  localparam logic [7:0] RST_PASSWORD = 8'hFF;
  localparam logic [5:0] RST_APPLIED = 6'h0E; // reset level code, already in range
endpackage : bbc_pkg

// >>> hw/bbc_sync.sv
// two-flop synchroniser for a group of independent pin levels
`timescale 1ns/1ps
module bbc_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one; // first flop, read only by the second

  // two flops per bit, both cleared in reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : bbc_sync

// >>> hw/bbc_ramp.sv
// output level stepper: one-step or timed upward ramp
`timescale 1ns/1ps
module bbc_ramp #(
  parameter int STEP_CYCLES = bbc_pkg::RAMP_STEP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ramp_on,
  input wire logic [bbc_pkg::LEVEL_W-1:0] target_code,
  output logic [bbc_pkg::LEVEL_W-1:0] level_code
);
  import bbc_pkg::*;
  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);
  logic [CNT_W-1:0] step_cnt; // cycles since last step

  // decreases and non-ramp changes land at once, increases step one code
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      level_code <= RST_APPLIED;
      step_cnt <= '0;
    end else if (!ramp_on || target_code <= level_code) begin
      level_code <= target_code;
      step_cnt <= '0;
    end else if (step_cnt == CNT_LAST) begin
      level_code <= level_code + 6'h01;
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // a rising ramp never moves by more than one code per cycle
  a_ramp_one_code: assert property (
    ramp_on && target_code > level_code |=> level_code <= $past(level_code) + 6'h01)
    else $error("ramp jumped more than one code");
  // the applied code never leaves the legal range
  a_level_in_range: assert property (level_code <= LEVEL_MAX)
    else $error("applied level above top code");
endmodule : bbc_ramp

// >>> hw/bbc_regs.sv
// regulator configuration register bank behind a two-wire serial slave port
// Contract
// - bit 7 of config a turns regulator on
// - ramp bit: one step, or 50mV/50us up
// - bit 5 selects pretrigger quick mode
// - zero-cross off changes only while disabled
// - bit 3 selects slowed switch-node edges
// - topology select changes only while disabled
// - bits 1 and 0 select shutdown drains
// - level bits 7:6 pick frequency thresholds
// - level code linear, saturates at 111100
// - peak limit a in bits 3:0
// - peak limit b in bits 7:4
// - adaptive off holds programmed peak currents
// - integrator enable changes only while disabled
// - switch halving changes only while disabled
// - fast mode is pin AND gate bit
// - bypass honoured only while regulator off
// - bit 5 selects internal supply source
// - status shows output ok, input low
// - status changes set event flags
// - block bits stop flags raising interrupt
// - 0xAA locks, 0x55 unlocks level field
// - guard bit disables password lock effect
// - answers bus address 0x28
// - pointer advances except at register 0x00
// - invalid register address gets not-acknowledge
`timescale 1ns/1ps
module bbc_regs #(
  parameter logic [7:0] CHIP_VERSION = 8'h5A // value is arbitrary
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic output_ok_in,
  input wire logic input_low_in,
  input wire logic pretrigger_pin,
  output logic regulator_on,
  output logic pretrigger_quick,
  output logic zero_cross_off,
  output logic slow_edge_sel,
  output logic topology_sel,
  output logic active_drain,
  output logic passive_drain,
  output logic [1:0] freq_hold_thresh,
  output logic [bbc_pkg::LEVEL_W-1:0] out_level_code,
  output logic [3:0] peak_limit_a,
  output logic [3:0] peak_limit_b,
  output logic fast_mode,
  output logic bypass_on,
  output logic supply_source_sel,
  output logic integrator_on,
  output logic adaptive_peak_off,
  output logic switch_halving,
  output logic irq_n
);
  import bbc_pkg::*;

  // serial engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_REG, ST_REG_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } bbc_state_type;

  bbc_state_type state; // serial engine state
  logic scl_s, sda_s, ok_s, low_s, pin_s; // synchronised pins
  logic scl_q, sda_q; // previous samples for edge finding
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [3:0] bit_cnt; // bits of current byte
  logic [7:0] rx_shift; // incoming byte
  logic [7:0] tx_shift; // outgoing byte
  logic [7:0] ptr; // register pointer
  logic [7:0] next_ptr; // pointer after a data byte
  logic read_mode; // read bit of the address byte
  logic rx_ack; // master acknowledge of last read byte
  logic wr_pulse; // one-cycle register write
  logic [7:0] wr_addr, wr_data;
  logic rd_clr; // one-cycle event flag read
  logic [7:0] read_byte; // read mux result
  logic reg_valid; // received register address is mapped
  logic load_now; // start sending a byte
  logic [7:0] cfg_a, level, peak, cfg_b; // configuration registers
  logic [1:0] suppress; // event block bits
  logic guard; // lock guard bit
  logic [7:0] password; // last password written
  logic locked; // level field write lock
  logic [1:0] status_q; // previous status sample
  logic [1:0] events; // sticky change flags
  logic [1:0] change; // status changed this cycle
  logic [5:0] target; // saturated level target

  // pins cross into the system clock domain
  bbc_sync #(.WIDTH(5)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({scl_in, sda_in, output_ok_in, input_low_in, pretrigger_pin}),
    .sync_out({scl_s, sda_s, ok_s, low_s, pin_s})
  );

  // previous bus samples, idle high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // bus edges and start/stop conditions
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;

  // mapped register addresses
  assign reg_valid = (rx_shift <= REG_SUPPRESS) || (rx_shift == REG_GUARD) ||
                     (rx_shift == REG_PASSWORD);
  // register 0x00 keeps the pointer in place
  assign next_ptr = (ptr == REG_CHIP) ? ptr : ptr + 8'h01;
  // a read byte starts at the falling edge closing an acknowledge
  assign load_now = scl_fall && ((state == ST_DEV_ACK && read_mode) ||
                                 (state == ST_RD_ACK && !rx_ack));

  // read mux, reserved bits read zero
  always_comb begin
    unique case (ptr)
      REG_CHIP: read_byte = CHIP_VERSION;
      REG_CFG_A: read_byte = cfg_a;
      REG_LEVEL: read_byte = level;
      REG_PEAK: read_byte = peak;
      REG_CFG_B: read_byte = cfg_b;
      REG_STATUS: read_byte = {6'h00, status_q};
      REG_EVENTS: read_byte = {6'h00, events};
      REG_SUPPRESS: read_byte = {6'h00, suppress};
      REG_GUARD: read_byte = {7'h00, guard};
      REG_PASSWORD: read_byte = password;
      default: read_byte = 8'h00;
    endcase
  end

  // serial engine: address, register pointer, data bytes, acknowledges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      ptr <= 8'h00;
      read_mode <= 1'b0;
      rx_ack <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_pulse <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      rd_clr <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      rd_clr <= 1'b0;
      sda_out <= 1'b0; // open drain: only ever pulls low
      if (start_cond) begin
        // start or repeated start
        state <= ST_DEV;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (load_now) begin
        // first bit of a read byte goes out
        state <= ST_RD;
        bit_cnt <= 4'h0;
        sda_oe_n <= read_byte[7];
        tx_shift <= {read_byte[6:0], 1'b0};
        ptr <= next_ptr;
        rd_clr <= (ptr == REG_EVENTS);
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe_n <= 1'b1; // wait for a start
          end
          ST_DEV, ST_REG, ST_WR: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (state == ST_DEV) begin
                if (rx_shift[7:1] == DEV_ADDR) begin
                  sda_oe_n <= 1'b0;
                  read_mode <= rx_shift[0];
                  state <= ST_DEV_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_REG) begin
                if (reg_valid) begin
                  sda_oe_n <= 1'b0;
                  ptr <= rx_shift;
                  state <= ST_REG_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                wr_pulse <= 1'b1;
                wr_addr <= ptr;
                wr_data <= rx_shift;
                ptr <= next_ptr;
                sda_oe_n <= 1'b0;
                state <= ST_WR_ACK;
              end
            end
          end
          ST_DEV_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state <= ST_REG; // write direction: register address next
            end
          end
          ST_REG_ACK, ST_WR_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                sda_oe_n <= 1'b1; // master's acknowledge slot
                state <= ST_RD_ACK;
              end else begin
                sda_oe_n <= tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              rx_ack <= sda_s;
            end else if (scl_fall) begin
              state <= ST_IDLE; // not-acknowledge ends the read
            end
          end
        endcase
      end
    end
  end

  // configuration registers; latched bits hold while enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_a <= RST_CFG_A;
      level <= RST_LEVEL;
      peak <= RST_PEAK;
      cfg_b <= RST_CFG_B;
      suppress <= RST_SUPPRESS;
    end else if (wr_pulse) begin
      unique case (wr_addr)
        REG_CFG_A: begin
          if (cfg_a[A_ON]) begin
            cfg_a <= (cfg_a & A_LATCH_MASK) | (wr_data & ~A_LATCH_MASK);
          end else begin
            cfg_a <= wr_data;
          end
        end
        REG_LEVEL: begin
          if (locked) begin
            level <= {wr_data[7:6], level[5:0]};
          end else begin
            level <= wr_data;
          end
        end
        REG_PEAK: begin
          peak <= wr_data;
        end
        REG_CFG_B: begin
          if (cfg_a[A_ON]) begin
            cfg_b <= (cfg_b & B_LATCH_MASK) | (wr_data & B_WRITE_MASK & ~B_LATCH_MASK);
          end else begin
            cfg_b <= wr_data & B_WRITE_MASK;
          end
        end
        REG_SUPPRESS: begin
          suppress <= wr_data[1:0];
        end
        default: begin
          cfg_a <= cfg_a; // read-only or lock registers: nothing here
        end
      endcase
    end
  end

  // password lock and its guard
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      guard <= RST_GUARD;
      password <= RST_PASSWORD;
      locked <= 1'b0;
    end else if (wr_pulse && wr_addr == REG_GUARD) begin
      guard <= wr_data[0];
    end else if (wr_pulse && wr_addr == REG_PASSWORD) begin
      password <= wr_data;
      if (!guard && wr_data == LOCK_CODE) begin
        locked <= 1'b1;
      end else if (!guard && wr_data == UNLOCK_CODE) begin
        locked <= 1'b0;
      end
    end
  end

  // status sample and sticky change flags; a new change beats a read clear
  assign change = {ok_s, low_s} ^ status_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 2'h0;
      events <= 2'h0;
    end else begin
      status_q <= {ok_s, low_s};
      events <= (rd_clr ? 2'h0 : events) | change;
    end
  end

  // derived registered outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fast_mode <= 1'b0;
      bypass_on <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      fast_mode <= pin_s & cfg_b[B_GATE];
      bypass_on <= cfg_b[B_BYPASS] & ~cfg_a[A_ON];
      irq_n <= ~|(events & ~suppress);
    end
  end

  // level target saturates at the top code
  assign target = (level[5:0] >= LEVEL_MAX) ? LEVEL_MAX : level[5:0];

  // applied output level, stepped or immediate
  bbc_ramp u_ramp (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ramp_on(cfg_a[A_RAMP]),
    .target_code(target),
    .level_code(out_level_code)
  );

  // register fields straight to the power stage
  assign regulator_on = cfg_a[A_ON];
  assign pretrigger_quick = cfg_a[A_QUICK];
  assign zero_cross_off = cfg_a[A_ZC_OFF];
  assign slow_edge_sel = cfg_a[A_SLOW];
  assign topology_sel = cfg_a[A_TOPO];
  assign active_drain = cfg_a[A_ACTIVE];
  assign passive_drain = cfg_a[A_PASSIVE];
  assign freq_hold_thresh = level[7:6];
  assign peak_limit_a = peak[3:0];
  assign peak_limit_b = peak[7:4];
  assign supply_source_sel = cfg_b[B_SUPPLY];
  assign integrator_on = cfg_b[B_INTEG];
  assign adaptive_peak_off = cfg_b[B_ADAPT];
  assign switch_halving = cfg_b[B_HALVE];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // a config write takes the enable bit next cycle
  a_enable_write: assert property (
    wr_pulse && wr_addr == REG_CFG_A |=> regulator_on == $past(wr_data[A_ON]))
    else $error("enable bit did not follow write");
  // latched bits keep their value across writes while enabled
  a_latched_hold: assert property (
    wr_pulse && wr_addr == REG_CFG_A && regulator_on |=>
      zero_cross_off == $past(zero_cross_off) && topology_sel == $past(topology_sel))
    else $error("latched bit changed while enabled");
  a_latch_b_hold: assert property (
    wr_pulse && wr_addr == REG_CFG_B && regulator_on |=>
      switch_halving == $past(switch_halving) && integrator_on == $past(integrator_on))
    else $error("latched config b bit changed while enabled");
  // bypass never drives one cycle after the regulator ran
  a_bypass_off: assert property (bypass_on |-> !$past(regulator_on))
    else $error("bypass while regulator enabled");
  // fast mode is the AND of pin and gate, one cycle later
  a_fast_and: assert property (
    fast_mode == $past(pin_s && cfg_b[B_GATE]))
    else $error("fast mode differs from pin and gate");
  // an output ok status change sets its flag next cycle
  a_flag_set: assert property (change[1] |=> events[1])
    else $error("output event flag not set");
  // a read clears flags unless a new change arrives
  a_flag_clear: assert property (rd_clr && change == 2'h0 |=> events == 2'h0)
    else $error("flags not cleared by read");
  // fully blocked flags never raise the interrupt
  a_irq_blocked: assert property ((events & ~suppress) == 2'h0 |=> irq_n)
    else $error("interrupt raised by blocked flag");
  // locked level field ignores writes
  a_lock_level: assert property (
    wr_pulse && wr_addr == REG_LEVEL && locked |=> level[5:0] == $past(level[5:0]))
    else $error("locked level field changed");
  // guard set: password writes leave the lock alone
  a_guard_lock: assert property (
    wr_pulse && wr_addr == REG_PASSWORD && guard |=> locked == $past(locked))
    else $error("lock changed under guard");
  // bad register address: acknowledge slot stays released
  sequence seq_bad_reg;
    state == ST_REG && scl_fall && bit_cnt == BYTE_BITS && !reg_valid;
  endsequence
  a_reg_nack: assert property (seq_bad_reg |=> sda_oe_n [*2])
    else $error("invalid register address acknowledged");
  // writes at register 0x00 keep the pointer
  a_ptr_hold: assert property (
    state == ST_WR && scl_fall && bit_cnt == BYTE_BITS && ptr == REG_CHIP |=> ptr == REG_CHIP)
    else $error("pointer moved at register 0x00");
endmodule : bbc_regs

// >>> testbench/bbc_host_model.sv
// two-wire bus master model that talks to the register port
`timescale 1ns/1ps
module bbc_host_model (
  input wire logic clk_sys,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  import bbc_pkg::*;
  logic ack; // register address acknowledge of the last transfer
  // bus idles high, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // a quarter of the 320 ns bus clock
  task automatic q;
    repeat (2) @(negedge clk_sys);
  endtask : q
  // start or repeated start: data falls while clock is high
  task automatic start;
    sda_drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask : start
  // stop: data rises while clock is high, then all released
  task automatic stop;
    sda_drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b1;
    q;
  endtask : stop
  // one bit, data held over the whole high phase
  task automatic bitx(input logic b, output logic r);
    sda_drv = b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask : bitx
  // eight bits msb first, then the ninth bit with the line released
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ok);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
    bitx(1'b1, b);
    ok = ~b;
  endtask : xfer
  // register write: address byte, register, one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    logic ok;
    start;
    xfer({DEV_ADDR, 1'b0}, r, ok);
    xfer(a, r, ok);
    ack = ok;
    if (ok) xfer(v, r, ok);
    stop;
  endtask : wr
  // two-byte burst write: the second byte lands on the next register
  task automatic wr2(input logic [7:0] a, input logic [7:0] v0, input logic [7:0] v1);
    logic [7:0] r;
    logic ok;
    start;
    xfer({DEV_ADDR, 1'b0}, r, ok);
    xfer(a, r, ok);
    xfer(v0, r, ok);
    xfer(v1, r, ok);
    stop;
  endtask : wr2
  // register read: pointer set, repeated start, one byte closed by a not-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic ok;
    start;
    xfer({DEV_ADDR, 1'b0}, v, ok);
    xfer(a, v, ok);
    ack = ok;
    start;
    xfer({DEV_ADDR, 1'b1}, v, ok);
    xfer(8'hFF, v, ok);
    stop;
  endtask : rd
endmodule : bbc_host_model

// >>> testbench/test_bbc_regs.sv
// self-checking bench for the register bank over the two-wire port
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module test_bbc_regs;
  import bbc_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} bbc_row_type;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ok_in = 1'b0;
  logic low_in = 1'b0;
  logic pin = 1'b0;
  logic scl, sda_drv, sda_out, sda_oe_n, on, zc, topo, fast, byp, irq_n;
  logic quick, slow, act, psv, sup, integ, adapt, halve; // further config outputs
  logic [1:0] fth;
  logic [3:0] pka, pkb;
  logic [5:0] lvl;
  logic [7:0] d;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire sda = sda_drv & (sda_oe_n | sda_out); // pulled up unless a party pulls low
  // ordinary cases with the regulator off: address, written, read back
  bbc_row_type rows [6] = '{
    '{8'h00, 8'h12, 8'h6E},
    '{8'h01, 8'h2B, 8'h2B},
    '{8'h03, 8'hA5, 8'hA5},
    '{8'h04, 8'hFF, 8'hE7},
    '{8'h07, 8'hFE, 8'h02},
    '{8'h02, 8'h7F, 8'h7F}};
  bbc_host_model bbc_host_model_i (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  bbc_regs #(.CHIP_VERSION(8'h6E)) bbc_regs_i ( // version value is arbitrary
    .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .output_ok_in(ok_in), .input_low_in(low_in),
    .pretrigger_pin(pin), .regulator_on(on), .pretrigger_quick(quick), .zero_cross_off(zc),
    .slow_edge_sel(slow), .topology_sel(topo), .active_drain(act), .passive_drain(psv),
    .freq_hold_thresh(fth), .out_level_code(lvl), .peak_limit_a(pka), .peak_limit_b(pkb),
    .fast_mode(fast), .bypass_on(byp), .supply_source_sel(sup), .integrator_on(integ),
    .adaptive_peak_off(adapt), .switch_halving(halve), .irq_n(irq_n));
  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop;
    end
  end
  // closing report, the only end of the run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // write then read back one register
  task automatic wrd(input logic [7:0] a, input logic [7:0] w);
    bbc_host_model_i.wr(a, w);
    bbc_host_model_i.rd(a, d);
  endtask : wrd
  // main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    bbc_host_model_i.rd(REG_CFG_A, d);
    `CHK("cfg a reset", RST_CFG_A, d)
    `CHK("level reset", RST_APPLIED, lvl)
    $display("test reset done");
    foreach (rows[i]) begin
      wrd(rows[i].a, rows[i].w);
      `CHK("readback", rows[i].r, d)
      `CHK("reg ack", 1'b1, bbc_host_model_i.ack)
    end
    `CHK("level sat", 6'h3C, lvl)
    `CHK("bypass off", 1'b1, byp)
    `CHK("cfg a outs", 7'h2B, {on, quick, zc, slow, topo, act, psv})
    `CHK("peak outs", 8'hA5, {pkb, pka})
    `CHK("cfg b outs", 4'hF, {sup, integ, adapt, halve})
    `CHK("freq outs", 2'h1, fth)
    pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK("fast", 1'b1, fast)
    $display("test rows done");
    wrd(REG_CFG_A, 8'h80);
    `CHK("on", 1'b1, on)
    `CHK("bypass on", 1'b0, byp)
    wrd(REG_CFG_A, 8'h94);
    `CHK("cfg a latch", 8'h80, d)
    `CHK("zc", 1'b0, zc | topo)
    wrd(REG_CFG_B, 8'h00);
    `CHK("cfg b latch", 8'h05, d)
    `CHK("cfg b pins", 4'h5, {sup, integ, adapt, halve})
    bbc_host_model_i.wr(REG_CFG_A, 8'h00);
    $display("test latch done");
    bbc_host_model_i.wr(REG_GUARD, 8'h00);
    bbc_host_model_i.wr(REG_PASSWORD, LOCK_CODE);
    wrd(REG_LEVEL, 8'h80);
    `CHK("locked", 8'hBF, d)
    bbc_host_model_i.wr(REG_PASSWORD, UNLOCK_CODE);
    wrd(REG_LEVEL, 8'h01);
    `CHK("unlocked", 8'h01, d)
    bbc_host_model_i.wr(REG_GUARD, 8'h01);
    bbc_host_model_i.wr(REG_PASSWORD, LOCK_CODE);
    wrd(REG_LEVEL, 8'h02);
    `CHK("guarded", 8'h02, d)
    $display("test lock done");
    // ramp on: an increase steps one code per step time, a decrease lands at once
    bbc_host_model_i.wr(REG_CFG_A, 8'h40);
    bbc_host_model_i.wr(REG_LEVEL, 8'h05);
    `CHK("ramp start", 6'h02, lvl)
    repeat (RAMP_STEP_CYCLES) @(negedge clk_sys);
    `CHK("ramp step", 6'h03, lvl)
    repeat (2 * RAMP_STEP_CYCLES + 100) @(negedge clk_sys);
    `CHK("ramp end", 6'h05, lvl)
    bbc_host_model_i.wr(REG_LEVEL, 8'h01);
    `CHK("ramp down", 6'h01, lvl)
    $display("test ramp done");
    low_in = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK("irq input", 1'b0, irq_n)
    ok_in = 1'b1;
    repeat (10) @(negedge clk_sys);
    bbc_host_model_i.rd(REG_EVENTS, d);
    `CHK("events", 8'h03, d)
    `CHK("irq clear", 1'b1, irq_n)
    ok_in = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("irq masked", 1'b1, irq_n)
    $display("test events done");
    bbc_host_model_i.wr(8'h08, 8'h00);
    `CHK("bad reg nack", 1'b0, bbc_host_model_i.ack)
    $display("test address done");
    // burst past the last mask register: second byte goes to an unmapped slot
    bbc_host_model_i.wr2(REG_SUPPRESS, 8'h03, 8'h00);
    bbc_host_model_i.rd(REG_SUPPRESS, d);
    `CHK("burst next", 8'h03, d)
    $display("test burst done");
    // reset again in mid-run
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    bbc_host_model_i.rd(REG_LEVEL, d);
    `CHK("level reset 2", RST_LEVEL, d)
    `CHK("applied reset 2", RST_APPLIED, lvl)
    $display("test reset again done");
    report_and_stop;
  end
endmodule : test_bbc_regs
